// >>> logic/ncs_pkg.sv
// constants shared by the network control/status flag block
package ncs_pkg;
	// ----------------------------------------------------------------
	// register positions and select codes
	// ----------------------------------------------------------------
	localparam logic [31:0] NET_DATA_PORT_ADDR = 32'h1008_4400;
	localparam logic [31:0] REGISTER_SELECT_PORT_ADDR = 32'h1008_4404;
	localparam logic [1:0] SEL_MAIN = 2'h0;
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam logic [15:0] MAIN_RESET = 16'h0004;

	// ----------------------------------------------------------------
	// bit positions of the main control/status register
	// ----------------------------------------------------------------
	localparam int BIT_ERR = 15;
	localparam int BIT_TX_TIMEOUT = 14;
	localparam int BIT_HEARTBEAT = 13;
	localparam int BIT_MISSED = 12;
	localparam int BIT_MEM_TIMEOUT = 11;
	localparam int BIT_RX_DONE = 10;
	localparam int BIT_TX_DONE = 9;
	localparam int BIT_SETUP_DONE = 8;
	localparam int BIT_IRQ_SUMMARY = 7;
	localparam int BIT_IRQ_ENABLE = 6;
	localparam int BIT_RX_ON = 5;
	localparam int BIT_TX_ON = 4;
	localparam int BIT_STOP = 2;
	localparam int FLAG_LO = 8;

	// flag vector index (bit position minus FLAG_LO)
	localparam int F_SETUP = 0;
	localparam int F_TXD = 1;
	localparam int F_RXD = 2;
	localparam int F_MEM = 3;
	localparam int F_MISS = 4;
	localparam int F_HB = 5;
	localparam int F_TXTO = 6;
	localparam logic [6:0] FLAGS_RESET = 7'h00;
	localparam logic [6:0] ERR_MASK = 7'h78;
	localparam logic [6:0] IRQ_MASK = 7'h5F;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int HEARTBEAT_WINDOW_NS = 2000;
	localparam int MEM_TIMEOUT_NS = 25600;
	localparam int HEARTBEAT_CYCLES = (HEARTBEAT_WINDOW_NS * 1000) / CLK_PERIOD_PS;
	localparam int MEM_TIMEOUT_CYCLES = (MEM_TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TX_TIMEOUT_BYTES = 1519;
	localparam int TMR_WIDTH = 16;
	localparam logic [15:0] TMR_CNT_RESET = 16'h0000;
endpackage

// >>> logic/ncs_tmr_if.sv
// start/halt/tick/expire handshake between the flag block and one counter
`timescale 1ns/1ps
interface ncs_tmr_if;
	logic start;
	logic halt;
	logic tick;
	logic expire;

	modport tmr (
		input start,
		input halt,
		input tick,
		output expire
	);
	modport ctl (
		output start,
		output halt,
		output tick,
		input expire
	);
endinterface

// >>> logic/ncs_tmr.sv
// limit counter: counts ticks after start, pulses expire on reaching the limit
`timescale 1ns/1ps
module ncs_tmr #(
	parameter int WIDTH = ncs_pkg::TMR_WIDTH,
	parameter logic [WIDTH-1:0] LIMIT = WIDTH'(1)
) (
	input wire logic clk,
	input wire logic rst_n,
	ncs_tmr_if.tmr bus
);
	typedef struct packed {
		logic run;
		logic [WIDTH-1:0] cnt;
		logic expire;
	} ncs_tmr_state_t;

	ncs_tmr_state_t s_r;
	ncs_tmr_state_t s_nxt;

	// ----------------------------------------------------------------
	// counting
	// ----------------------------------------------------------------
	// halt wins over start so a stopped engine never leaves a counter armed
	always_comb begin
		s_nxt = s_r;
		s_nxt.expire = 1'b0;
		if (bus.halt) begin
			s_nxt.run = 1'b0;
			s_nxt.cnt = '0;
		end else if (bus.start) begin
			s_nxt.run = 1'b1;
			s_nxt.cnt = '0;
		end else if (s_r.run && bus.tick) begin
			if (s_r.cnt + WIDTH'(1) == LIMIT) begin
				s_nxt.expire = 1'b1; // one pulse, then idle until next start
				s_nxt.run = 1'b0;
				s_nxt.cnt = '0;
			end else begin
				s_nxt.cnt = s_r.cnt + WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bus.expire = s_r.expire;
endmodule

// >>> logic/ncs_main.sv
// main control/status register flags, error and interrupt summaries
//
// Summary of operation
// - select 00 shows this 16-bit register; reads never change any bit.
// - power-up clears every bit except stop, which is set.
// - error summary bit 15 is OR of four error flags, read only.
// - transmit timeout flag sets after 1519 bytes of one frame, raises both summaries.
// - missed packet flag sets on dropped frame; ignored in internal loopback.
// - memory timeout flag sets when a buffer access waits 25.6 us unanswered.
// - memory timeout turns receiver and transmitter off.
// - receive done flag sets on last receive entry update or receive failure.
// - transmit done flag sets on last transmit entry update or transmit failure.
// - setup done flag sets once the init block has been read and stored.
// - flags 14 to 8 clear on host write of one, unchanged on zero.
// - flags 15 to 6 clear on stop, power-up and while io reset asserted.
// - interrupt summary bit 7 is OR of all flags except heartbeat, read only.
// - interrupt request posted while summary and enable are both set.
// - interrupt enable bit 6 is read/write, cleared by stop, power-up, io reset.
// - setting stop halts activity and clears every other bit.
// - bits 5 and 4 are read-only receiver/transmitter on, cleared by memory timeout.
`timescale 1ns/1ps
module ncs_main #(
	parameter int MEM_TIMEOUT_CYCLES = ncs_pkg::MEM_TIMEOUT_CYCLES
) (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic IO_RESET,
	input wire logic HOST_ADDR_SEL,
	input wire logic HOST_WR,
	input wire logic HOST_RD,
	input wire logic [15:0] HOST_WDATA,
	output logic [15:0] HOST_RDATA,
	input wire logic TX_FRAME_START,
	input wire logic TX_BYTE,
	input wire logic TX_FRAME_END,
	input wire logic TX_SELF_DONE,
	input wire logic COLLISION,
	input wire logic RX_MISS,
	input wire logic LOOPBACK_INT,
	input wire logic DMA_START,
	input wire logic DMA_READY,
	input wire logic RX_DONE,
	input wire logic TX_DONE,
	input wire logic SETUP_DONE,
	input wire logic RX_ENABLE_SET,
	input wire logic TX_ENABLE_SET,
	input wire logic RUN_ACCEPT,
	output logic RX_ON,
	output logic TX_ON,
	output logic STOP_OUT,
	output logic IRQ_REQ
);
	typedef struct packed {
		logic iorst_m;
		logic iorst;
		logic coll_m;
		logic coll;
		logic [1:0] sel;
		logic stop;
		logic ien;
		logic [6:0] flags;
		logic receiver_on_flag;
		logic transmitter_on_flag;
		logic [15:0] rdata;
		logic irq;
	} ncs_main_state_t;

	ncs_main_state_t s_r;
	ncs_main_state_t s_nxt;

	ncs_tmr_if txto_if ();
	ncs_tmr_if hb_if ();
	ncs_tmr_if dma_if ();

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// register image; summaries are pure ORs, so they can never disagree with the flags
	function automatic logic [15:0] ncs_image(input ncs_main_state_t s);
		logic [15:0] v;
		v = 16'h0000;
		v[ncs_pkg::BIT_ERR] = |(s.flags & ncs_pkg::ERR_MASK);
		v[ncs_pkg::BIT_TX_TIMEOUT:ncs_pkg::FLAG_LO] = s.flags;
		v[ncs_pkg::BIT_IRQ_SUMMARY] = |(s.flags & ncs_pkg::IRQ_MASK);
		v[ncs_pkg::BIT_IRQ_ENABLE] = s.ien;
		v[ncs_pkg::BIT_RX_ON] = s.receiver_on_flag;
		v[ncs_pkg::BIT_TX_ON] = s.transmitter_on_flag;
		v[ncs_pkg::BIT_STOP] = s.stop;
		return v;
	endfunction

	// ----------------------------------------------------------------
	// counters
	// ----------------------------------------------------------------
	// byte count of the current frame; frame end or stop disarms it
	assign txto_if.start = TX_FRAME_START & ~s_r.stop;
	assign txto_if.halt = TX_FRAME_END | s_r.stop;
	assign txto_if.tick = TX_BYTE;
	// heartbeat window opens when our own transmission ends, a collision closes it
	assign hb_if.start = TX_SELF_DONE & ~s_r.stop;
	assign hb_if.halt = s_r.coll | s_r.stop;
	assign hb_if.tick = 1'b1;
	// buffer access watchdog, closed by the ready answer
	assign dma_if.start = DMA_START & ~s_r.stop;
	assign dma_if.halt = DMA_READY | s_r.stop;
	assign dma_if.tick = 1'b1;

	ncs_tmr #(
		.WIDTH(ncs_pkg::TMR_WIDTH),
		.LIMIT(16'(ncs_pkg::TX_TIMEOUT_BYTES))
	) u_txto (
		.clk(REF_CLK),
		.rst_n(RESETN),
		.bus(txto_if.tmr)
	);

	ncs_tmr #(
		.WIDTH(ncs_pkg::TMR_WIDTH),
		.LIMIT(16'(ncs_pkg::HEARTBEAT_CYCLES))
	) u_hb (
		.clk(REF_CLK),
		.rst_n(RESETN),
		.bus(hb_if.tmr)
	);

	ncs_tmr #(
		.WIDTH(ncs_pkg::TMR_WIDTH),
		.LIMIT(16'(MEM_TIMEOUT_CYCLES))
	) u_dma (
		.clk(REF_CLK),
		.rst_n(RESETN),
		.bus(dma_if.tmr)
	);

	// ----------------------------------------------------------------
	// register behaviour
	// ----------------------------------------------------------------
	always_comb begin
		logic main_wr;
		logic stop_now;
		logic [6:0] set_v;
		logic [6:0] clr_v;
		logic [15:0] nxt_img;
		main_wr = 1'b0;
		nxt_img = 16'h0000;
		stop_now = 1'b0;
		set_v = 7'h00;
		clr_v = 7'h00;
		s_nxt = s_r;
		// io reset and collision inputs pass two flops before use
		s_nxt.iorst_m = IO_RESET;
		s_nxt.iorst = s_r.iorst_m;
		s_nxt.coll_m = COLLISION;
		s_nxt.coll = s_r.coll_m;

		main_wr = HOST_WR && !HOST_ADDR_SEL && s_r.sel == ncs_pkg::SEL_MAIN;
		stop_now = s_r.iorst || (main_wr && HOST_WDATA[ncs_pkg::BIT_STOP]);

		// events are dropped while stopped: the engines are held idle then
		if (!s_r.stop) begin
			set_v[ncs_pkg::F_TXTO] = txto_if.expire;
			set_v[ncs_pkg::F_HB] = hb_if.expire;
			set_v[ncs_pkg::F_MISS] = RX_MISS & ~LOOPBACK_INT;
			set_v[ncs_pkg::F_MEM] = dma_if.expire;
			set_v[ncs_pkg::F_RXD] = RX_DONE;
			set_v[ncs_pkg::F_TXD] = TX_DONE;
			set_v[ncs_pkg::F_SETUP] = SETUP_DONE;
		end
		if (main_wr) begin
			clr_v = HOST_WDATA[ncs_pkg::BIT_TX_TIMEOUT:ncs_pkg::FLAG_LO];
		end

		if (stop_now) begin
			// stop wins over every other write in the same access
			s_nxt.stop = 1'b1;
			s_nxt.flags = ncs_pkg::FLAGS_RESET;
			s_nxt.ien = 1'b0;
			s_nxt.receiver_on_flag = 1'b0;
			s_nxt.transmitter_on_flag = 1'b0;
			s_nxt.sel = ncs_pkg::SEL_RESET;
		end else begin
			s_nxt.flags = (s_r.flags & ~clr_v) | set_v;
			if (main_wr) begin
				s_nxt.ien = HOST_WDATA[ncs_pkg::BIT_IRQ_ENABLE];
			end
			if (RUN_ACCEPT) begin
				s_nxt.stop = 1'b0;
			end
			if (RX_ENABLE_SET && !s_r.stop) begin
				s_nxt.receiver_on_flag = 1'b1;
			end
			if (TX_ENABLE_SET && !s_r.stop) begin
				s_nxt.transmitter_on_flag = 1'b1;
			end
			// a memory timeout shuts both directions down
			if (set_v[ncs_pkg::F_MEM]) begin
				s_nxt.receiver_on_flag = 1'b0;
				s_nxt.transmitter_on_flag = 1'b0;
			end
			if (HOST_WR && HOST_ADDR_SEL) begin
				s_nxt.sel = HOST_WDATA[1:0];
			end
		end

		// reads are side-effect free; other selects read zero here
		if (HOST_RD) begin
			if (HOST_ADDR_SEL) begin
				s_nxt.rdata = {14'h0000, s_r.sel};
			end else if (s_r.sel == ncs_pkg::SEL_MAIN) begin
				s_nxt.rdata = ncs_image(s_r);
			end else begin
				s_nxt.rdata = 16'h0000;
			end
		end

		// request follows the next image so it moves on the same edge as the flag or enable
		nxt_img = ncs_image(s_nxt);
		s_nxt.irq = nxt_img[ncs_pkg::BIT_IRQ_SUMMARY] & s_nxt.ien;
	end

	// power-up leaves only stop set
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			s_r <= '0;
			s_r.stop <= 1'b1;
			s_r.sel <= ncs_pkg::SEL_RESET;
			s_r.flags <= ncs_pkg::FLAGS_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign HOST_RDATA = s_r.rdata;
	assign RX_ON = s_r.receiver_on_flag;
	assign TX_ON = s_r.transmitter_on_flag;
	assign STOP_OUT = s_r.stop;
	assign IRQ_REQ = s_r.irq;
endmodule

// >>> sim/ncs_host.sv
// host-side model driving the address/data register port pair
`timescale 1ns/1ps
module ncs_host (
	input wire logic clk,
	output logic sel,
	output logic wr,
	output logic rd,
	output logic [15:0] wdata,
	input wire logic [15:0] rdata
);
	initial begin
		sel = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 16'h0000;
	end
	// --------
	// one access: strobe for one edge, answer taken once that edge's update has landed
	// --------
	// only a 16-bit path exists, so the undefined upper half is never touched
	task automatic acc(input logic a, input logic w, input logic [15:0] dat, output logic [15:0] q);
		@(posedge clk);
		#1 sel = a;
		wr = w;
		rd = !w;
		wdata = dat;
		@(posedge clk);
		#1 q = rdata;
		wr = 1'b0;
		rd = 1'b0;
	endtask
endmodule

// >>> sim/ncs_chk_props.sv
// port-level checker for the control/status flag block
`timescale 1ns/1ps
module ncs_chk (
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic IO_RESET,
	input wire logic HOST_ADDR_SEL,
	input wire logic HOST_WR,
	input wire logic HOST_RD,
	input wire logic [15:0] HOST_WDATA,
	input wire logic [15:0] HOST_RDATA,
	input wire logic RX_ON,
	input wire logic TX_ON,
	input wire logic STOP_OUT,
	input wire logic IRQ_REQ
);
	logic [1:0] sel_r;
	logic rd0;
	default clocking cb @(posedge REF_CLK); endclocking
	// io reset lags through a synchroniser, so checks pause while it is up
	default disable iff (!RESETN || IO_RESET);
	// --------
	// shadow of the select port, so data port reads can be judged
	// --------
	always_ff @(posedge REF_CLK or negedge RESETN) begin
		if (!RESETN) begin
			sel_r <= 2'h0;
		end else if (IO_RESET) begin
			sel_r <= 2'h0;
		end else if (HOST_WR && HOST_ADDR_SEL) begin
			sel_r <= HOST_WDATA[1:0];
		end
	end
	assign rd0 = HOST_RD && !HOST_ADDR_SEL && (sel_r == 2'h0);
	property p_err; rd0 |=> HOST_RDATA[15] == (|HOST_RDATA[14:11]); endproperty
	a_err: assert property (p_err) else $error("error summary wrong");
	property p_sum; rd0 |=> HOST_RDATA[7] == (HOST_RDATA[14] | (|HOST_RDATA[12:8])); endproperty
	a_sum: assert property (p_sum) else $error("interrupt summary wrong");
	property p_img; rd0 |=> HOST_RDATA[5:4] == $past({RX_ON, TX_ON}) && HOST_RDATA[2] == $past(STOP_OUT); endproperty
	a_img: assert property (p_img) else $error("read image disagrees with pins");
	property p_irq; rd0 |=> (HOST_RDATA[7] & HOST_RDATA[6]) == $past(IRQ_REQ); endproperty
	a_irq: assert property (p_irq) else $error("interrupt request wrong");
	property p_sel; HOST_RD && HOST_ADDR_SEL |=> HOST_RDATA == {14'h0000, $past(sel_r)}; endproperty
	a_sel: assert property (p_sel) else $error("select port read wrong");
	property p_hold; !HOST_RD |=> $stable(HOST_RDATA); endproperty
	a_hold: assert property (p_hold) else $error("read data moved without a read");
	property p_stop_wr; HOST_WR && !HOST_ADDR_SEL && sel_r == 2'h0 && HOST_WDATA[2] |=> STOP_OUT && !IRQ_REQ; endproperty
	a_stop_wr: assert property (p_stop_wr) else $error("stop write did not stop");
	property p_stopped; STOP_OUT |=> !RX_ON && !TX_ON && !IRQ_REQ; endproperty
	a_stopped: assert property (p_stopped) else $error("activity while stopped");
	c_rd: cover property (rd0 ##1 HOST_RDATA[7]);
	c_irq: cover property ($rose(IRQ_REQ));
	c_off: cover property ($fell(RX_ON) && !STOP_OUT);
endmodule
bind ncs_main ncs_chk i_ncs_chk (.REF_CLK(REF_CLK), .RESETN(RESETN), .IO_RESET(IO_RESET),
	.HOST_ADDR_SEL(HOST_ADDR_SEL), .HOST_WR(HOST_WR), .HOST_RD(HOST_RD), .HOST_WDATA(HOST_WDATA),
	.HOST_RDATA(HOST_RDATA), .RX_ON(RX_ON), .TX_ON(TX_ON), .STOP_OUT(STOP_OUT), .IRQ_REQ(IRQ_REQ));

// >>> sim/tb_top.sv
// self-checking bench for the control/status flag block
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic io_rst = 1'b0;
	logic lb = 1'b0;
	logic col = 1'b0;
	logic txb = 1'b0;
	logic [11:0] ev = 12'h000;
	logic sel, wr, rd, rx_on, tx_on, stop, irq;
	logic [15:0] wdata, rdata, d;
	logic [6:0] fl = 7'h00;
	logic [31:0] r;
	int seed = 11;
	int error_cnt = 0;
	int cmp_count = 0;
	always #2.5 clk = ~clk;
	// short memory timeout keeps the run brief
	ncs_main #(.MEM_TIMEOUT_CYCLES(20)) i_ncs_main (.REF_CLK(clk), .RESETN(rst_n), .IO_RESET(io_rst),
		.HOST_ADDR_SEL(sel), .HOST_WR(wr), .HOST_RD(rd), .HOST_WDATA(wdata), .HOST_RDATA(rdata),
		.TX_FRAME_START(ev[4]), .TX_BYTE(txb), .TX_FRAME_END(ev[5]), .TX_SELF_DONE(ev[6]), .COLLISION(col),
		.RX_MISS(ev[3]), .LOOPBACK_INT(lb), .DMA_START(ev[7]), .DMA_READY(ev[8]), .RX_DONE(ev[0]),
		.TX_DONE(ev[1]), .SETUP_DONE(ev[2]), .RX_ENABLE_SET(ev[9]), .TX_ENABLE_SET(ev[10]),
		.RUN_ACCEPT(ev[11]), .RX_ON(rx_on), .TX_ON(tx_on), .STOP_OUT(stop), .IRQ_REQ(irq));
	ncs_host i_host (.clk(clk), .sel(sel), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata));
	// --------
	// helpers
	// --------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic pulse(input logic [11:0] m);
		@(posedge clk);
		#1 ev = m;
		@(posedge clk);
		#1 ev = 12'h000;
	endtask
	task automatic wrr(input logic a, input logic [15:0] v);
		i_host.acc(a, 1'b1, v, d);
	endtask
	task automatic rdm(input logic [15:0] e);
		i_host.acc(1'b0, 1'b0, 16'h0000, d);
		chk(d, e);
	endtask
	// expected image with the enable bit set
	function automatic logic [15:0] img(input logic [6:0] f);
		img = {|f[6:3], f, |{f[6], f[4:0]}, 7'h40};
	endfunction
	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		end_sim();
	end
	initial begin
		cyc(20);
		rst_n = 1'b1;
		rdm(16'h0004);
		pulse(12'h001);
		rdm(16'h0004);
		pulse(12'h800);
		wrr(1'b0, 16'h0040);
		rdm(16'h0040);
		// random events and write-one-to-clear, read-only bits written too
		repeat (24) begin
			r = $random(seed);
			lb = r[4];
			pulse({8'h00, r[3:0]});
			fl = fl | {2'b00, r[3] & ~r[4], 1'b0, r[0], r[1], r[2]};
			rdm(img(fl));
			chk(irq, |{fl[6], fl[4:0]});
			wrr(1'b0, {r[15:7], 1'b1, r[5:3], 1'b0, r[1:0]});
			fl = fl & ~r[14:8];
			rdm(img(fl));
		end
		// a set beats a clear in the same cycle
		fork
			pulse(12'h001);
			wrr(1'b0, 16'h0440);
		join
		rdm(img(fl | 7'h04));
		wrr(1'b0, 16'h7F40);
		pulse(12'h040);
		cyc(10);
		col = 1'b1;
		cyc(3);
		col = 1'b0;
		cyc(420);
		rdm(16'h0040);
		pulse(12'h040);
		cyc(420);
		rdm(16'hA040);
		chk(irq, 1'b0);
		wrr(1'b0, 16'h2040);
		// byte count boundary: one short of the limit, then the limit
		pulse(12'h010);
		txb = 1'b1;
		cyc(1518);
		txb = 1'b0;
		cyc(4);
		rdm(16'h0040);
		txb = 1'b1;
		cyc(1);
		txb = 1'b0;
		cyc(3);
		rdm(16'hC0C0);
		pulse(12'h020);
		wrr(1'b0, 16'h4040);
		pulse(12'h600);
		chk({rx_on, tx_on}, 2'h3);
		pulse(12'h080);
		pulse(12'h100);
		cyc(30);
		rdm(16'h0070);
		pulse(12'h080);
		cyc(30);
		chk({rx_on, tx_on}, 2'h0);
		rdm(16'h88C0);
		// other selects: data port writes refused
		wrr(1'b1, 16'h0001);
		i_host.acc(1'b1, 1'b0, 16'h0000, d);
		chk(d, 16'h0001);
		wrr(1'b0, 16'h0004);
		chk(stop, 1'b0);
		wrr(1'b1, 16'h0000);
		wrr(1'b0, 16'h0004);
		rdm(16'h0004);
		pulse(12'h800);
		pulse(12'h001);
		wrr(1'b0, 16'h0040);
		io_rst = 1'b1;
		cyc(4);
		io_rst = 1'b0;
		cyc(2);
		rdm(16'h0004);
		chk(irq, 1'b0);
		end_sim();
	end
endmodule
